// ### hdl/irq_ctrl_pkg.sv
// Shared register map, field positions and reset values of the interrupt controller
package irq_ctrl_pkg;

	// Register port widths
	localparam int ADDR_W  = 6;
	localparam int DATA_W  = 8;
	localparam int CMD_W   = 4;
	localparam int TIMER_W = 16;

	// Register offsets
	localparam logic [ADDR_W-1:0] PRIM_EN_ADDR  = 6'h02;
	localparam logic [ADDR_W-1:0] SEC_EN_ADDR   = 6'h03;
	localparam logic [ADDR_W-1:0] PRIM_REQ_ADDR = 6'h04;
	localparam logic [ADDR_W-1:0] SEC_REQ_ADDR  = 6'h05;

	// Reset values
	localparam logic [DATA_W-1:0] PRIM_EN_RESET  = 8'h80;
	localparam logic [DATA_W-1:0] SEC_EN_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] PRIM_REQ_RESET = 8'h14;
	localparam logic [DATA_W-1:0] SEC_REQ_RESET  = 8'h00;

	// Bit 7 of each register: polarity, drive select, set/clear select
	localparam int POLARITY_BIT  = 7;
	localparam int DRIVE_BIT     = 7;
	localparam int SET_CLEAR_BIT = 7;

	// Primary request and enable bit positions
	localparam int TX_BIT        = 6;
	localparam int RX_BIT        = 5;
	localparam int CMD_END_BIT   = 4;
	localparam int HIGH_BIT      = 3;
	localparam int LOW_BIT       = 2;
	localparam int FAULT_BIT     = 1;
	localparam int COUNTDOWN_BIT = 0;
	localparam int PRIM_REQ_W    = 7;

	// Secondary request and enable bit positions
	localparam int AUX_BIT      = 4;
	localparam int CHECKSUM_BIT = 2;
	localparam int SEC_REQ_W    = 2;
	localparam int AUX_IDX      = 1;
	localparam int CHECKSUM_IDX = 0;

	// Pin synchroniser fill count
	localparam logic [1:0] SYNC_FILL = 2'h3;

	// Command field code of the idle command
	localparam logic [CMD_W-1:0] CMD_IDLE = 4'h0;

endpackage

// ### hdl/pin_edge_sync.sv
// Three-stage pin synchroniser with debounced level and any-edge pulse
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic pin_i,   // Asynchronous pin
	output logic      level_o, // Accepted level
	output logic      edge_o   // One-cycle pulse on either edge
);

	// Whole state of the synchroniser
	typedef struct packed {
		logic s1;     // First stage, read only by s2
		logic s2;
		logic s3;
		logic primed; // First agreement seen after reset
		logic level;
		logic edge_p;
		logic [1:0] fill; // Cycles since reset, held at SYNC_FILL
	} sync_state_t;

	sync_state_t q, d;

	// Next state: a change counts once stages two and three agree
	always_comb begin
		d        = q;
		d.s1     = pin_i;
		d.s2     = q.s1;
		d.s3     = q.s2;
		d.edge_p = 1'b0;
		// Reset zeros in the stages are no pin data
		if (q.fill != irq_ctrl_pkg::SYNC_FILL) begin
			d.fill = q.fill + 2'h1;
		end
		if ((q.fill == irq_ctrl_pkg::SYNC_FILL) && (q.s2 == q.s3)) begin
			// First agreement only loads the level, so a strap held at reset is no edge
			d.primed = 1'b1;
			d.level  = q.s3;
			d.edge_p = q.primed && (q.s3 != q.level);
		end
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_o = q.level;
	assign edge_o  = q.edge_p;

endmodule

`default_nettype wire

// ### hdl/irq_request_bank.sv
// Sticky request bits with write-side set or clear of the marked bits
`timescale 1ns/100ps
`default_nettype none

module irq_request_bank #(
	parameter int           W         = 7,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         wr_i,      // Register write strobe
	input  wire logic [W-1:0] mark_i,    // Bits written as one
	input  wire logic         set_sel_i, // One sets marked bits, zero clears them
	input  wire logic [W-1:0] event_i,   // Hardware set pulses
	output logic      [W-1:0] req_o      // Latched requests
);

	// Elaboration check on the width
	if (W < 1) begin : g_bad_width
		$error("irq_request_bank needs at least one bit");
	end

	// Whole state of the bank
	typedef struct packed {
		logic [W-1:0] req;
	} bank_state_t;

	bank_state_t q, d;

	// Next state: write first, then hardware events, so a set beats a clear
	always_comb begin
		d = q;
		if (wr_i && set_sel_i) begin
			d.req = q.req | mark_i;
		end else if (wr_i) begin
			d.req = q.req & ~mark_i;
		end
		// Events only set; nothing but a write ever clears
		d.req = d.req | event_i;
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q.req <= RESET_VAL;
		end else begin
			q <= d;
		end
	end

	assign req_o = q.req;

endmodule

`default_nettype wire

// ### hdl/reader_irq_controller.sv
// Interrupt request latching, enabling and pin drive of the reader
//
// Function
// - Polarity bit one inverts pin against status
// - Primary enable resets 80h; pin then floats
// - Primary enable bits 6..0 gate seven requests
// - Secondary enable bit 7 picks push-pull
// - Secondary bits 4, 2 gate aux, checksum
// - Primary write: bit 7 sets/clears marked bits
// - Transmit-done set after last bit sent
// - Receive-done on stream end, optionally needs data
// - Command-end set when command returns to idle
// - Unknown command forces idle, sets command-end
// - Host writing idle sets no command-end
// - FIFO-high request latches on status rise
// - FIFO-low request latches on status rise
// - Fault request set when any error rises
// - Countdown request set when timer reaches zero
// - Primary request resets to 14h
// - Secondary request: select 7, aux 4, checksum 2
// - Secondary write: bit 7 sets/clears marked bits
// - Aux request set on either input edge
// - Checksum request when compute done processing
`timescale 1ns/100ps
`default_nettype none

module reader_irq_controller #(
	// Bit n set means command code n is a known command
	parameter logic [15:0] KNOWN_CMD_MASK = 16'h00FF
) (
	input  wire logic                               clock_i,
	input  wire logic                               rst_i,
	// Register port
	input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]    reg_addr_i,
	input  wire logic                               reg_wr_i,
	input  wire logic                               reg_rd_i,
	input  wire logic [irq_ctrl_pkg::DATA_W-1:0]    reg_wdata_i,
	output logic      [irq_ctrl_pkg::DATA_W-1:0]    reg_rdata_o,
	// Transmitter and receiver
	input  wire logic                               tx_last_bit_sent_i,
	input  wire logic                               rx_stream_end_i,
	input  wire logic                               rx_ignore_empty_option_i,
	input  wire logic                               fifo_has_data_i,
	// FIFO level alerts
	input  wire logic                               fifo_high_status_i,
	input  wire logic                               fifo_low_status_i,
	// Error flags and timer
	input  wire logic [irq_ctrl_pkg::DATA_W-1:0]    error_flag_register_i,
	input  wire logic [irq_ctrl_pkg::TIMER_W-1:0]   timer_count_register_i,
	// Command sequencer
	input  wire logic [irq_ctrl_pkg::CMD_W-1:0]     command_register_i,
	input  wire logic                               cmd_host_idle_write_i,
	input  wire logic                               cmd_start_i,
	input  wire logic [irq_ctrl_pkg::CMD_W-1:0]     cmd_start_code_i,
	output logic                                    cmd_force_idle_o,
	// Checksum coprocessor
	input  wire logic                               checksum_compute_active_i,
	input  wire logic                               checksum_data_done_i,
	// Auxiliary serial input pin
	input  wire logic                               aux_serial_input_i,
	// Interrupt outputs
	output logic                                    irq_status_o,
	output logic                                    irq_pin_o,
	output logic                                    irq_pin_oe_o
);

	// Elaboration check: the idle code must itself be a known command
	if (!KNOWN_CMD_MASK[irq_ctrl_pkg::CMD_IDLE]) begin : g_bad_mask
		$error("KNOWN_CMD_MASK must include the idle command");
	end

	// One mask bit per command code
	if ($bits(KNOWN_CMD_MASK) != (1 << irq_ctrl_pkg::CMD_W)) begin : g_mask_w
		$error("KNOWN_CMD_MASK width wrong");
	end

	// Select bit above all request bits
	if (irq_ctrl_pkg::SET_CLEAR_BIT < irq_ctrl_pkg::PRIM_REQ_W) begin : g_layout
		$error("set/clear select overlaps a request");
	end

	// Whole state of the controller outside the request banks
	// History fields: each source one cycle back
	typedef struct packed {
		logic [irq_ctrl_pkg::DATA_W-1:0] prim_en;    // Polarity plus seven enables
		logic                            drive_sel;  // Push-pull when one
		logic                            aux_en;     // Aux activity enable
		logic                            chk_en;     // Checksum enable
		logic [irq_ctrl_pkg::CMD_W-1:0]  cmd_prev;   // Command field last cycle
		logic                            idle_wr;    // Host idle write last cycle
		logic [irq_ctrl_pkg::DATA_W-1:0] err_prev;   // Error flags last cycle
		logic                            high_prev;  // FIFO-high status last cycle
		logic                            low_prev;   // FIFO-low status last cycle
		logic                            tmr_nz;     // Timer was non-zero
		logic                            chk_prev;   // Checksum finish last cycle
		logic [irq_ctrl_pkg::DATA_W-1:0] rdata;      // Read data
		logic                            status;     // Global interrupt status
		logic                            pin;        // Pin output value
		logic                            pin_oe;     // Pin output enable
		logic                            force_idle; // Unknown command pulse
	} ctrl_state_t;

	ctrl_state_t q, d;

	// Banks own the set/clear state
	// Request bank outputs
	logic [irq_ctrl_pkg::PRIM_REQ_W-1:0] prim_req;
	logic [irq_ctrl_pkg::SEC_REQ_W-1:0]  sec_req;

	// Hardware event pulses into the banks
	logic [irq_ctrl_pkg::PRIM_REQ_W-1:0] prim_evt;
	logic [irq_ctrl_pkg::SEC_REQ_W-1:0]  sec_evt;

	// Decoded register writes
	logic                                prim_req_wr;
	logic                                sec_req_wr;
	logic [irq_ctrl_pkg::SEC_REQ_W-1:0]  sec_mark;

	// Aux pin after synchronisation
	logic                                aux_edge;

	// Decoded address test, used by every register
	// One function keeps all write decodes alike
	function automatic logic hit(
		input logic [irq_ctrl_pkg::ADDR_W-1:0] addr,
		input logic [irq_ctrl_pkg::ADDR_W-1:0] target
	);
		hit = (addr == target);
	endfunction

	// Rising edge of a level against its previous value
	function automatic logic rose(input logic now_v, input logic prev_v);
		rose = now_v && !prev_v;
	endfunction

	// Request write strobes
	// Only one register decodes per write
	assign prim_req_wr = reg_wr_i && hit(reg_addr_i, irq_ctrl_pkg::PRIM_REQ_ADDR);
	assign sec_req_wr  = reg_wr_i && hit(reg_addr_i, irq_ctrl_pkg::SEC_REQ_ADDR);

	// Secondary marks gathered from their scattered bit positions
	// Reserved write bits are dropped
	assign sec_mark[irq_ctrl_pkg::AUX_IDX]      = reg_wdata_i[irq_ctrl_pkg::AUX_BIT];
	assign sec_mark[irq_ctrl_pkg::CHECKSUM_IDX] = reg_wdata_i[irq_ctrl_pkg::CHECKSUM_BIT];

	// Aux input comes from a pin: synchronise, then take either edge
	// Level output unused; edges suffice
	pin_edge_sync u_aux_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (aux_serial_input_i),
		.level_o (),
		.edge_o  (aux_edge)
	);

	// Primary event sources
	always_comb begin
		prim_evt = '0;
		// Transmitter pulse arrives once the final bit has left
		prim_evt[irq_ctrl_pkg::TX_BIT] = tx_last_bit_sent_i;
		// With the option on, an empty FIFO suppresses the request
		// FIFO level taken with the stream end
		prim_evt[irq_ctrl_pkg::RX_BIT] = rx_stream_end_i
			&& (!rx_ignore_empty_option_i || fifo_has_data_i);
		// Any command to idle, unless the host wrote idle itself
		// Host pulse may lead the field
		// change by one cycle
		prim_evt[irq_ctrl_pkg::CMD_END_BIT] =
			((command_register_i == irq_ctrl_pkg::CMD_IDLE)
			&& (q.cmd_prev != irq_ctrl_pkg::CMD_IDLE)
			&& !cmd_host_idle_write_i && !q.idle_wr)
			|| (cmd_start_i && !KNOWN_CMD_MASK[cmd_start_code_i]);
		// Level alerts count only on their rising edge
		// A level held high fires once
		prim_evt[irq_ctrl_pkg::HIGH_BIT] = rose(fifo_high_status_i, q.high_prev);
		prim_evt[irq_ctrl_pkg::LOW_BIT]  = rose(fifo_low_status_i, q.low_prev);
		// Any single flag rising is enough
		prim_evt[irq_ctrl_pkg::FAULT_BIT] = |(error_flag_register_i & ~q.err_prev);
		// Count reached zero from a non-zero value
		// A timer loaded with zero is silent
		prim_evt[irq_ctrl_pkg::COUNTDOWN_BIT] = q.tmr_nz
			&& (timer_count_register_i == '0);
	end

	// Secondary event sources
	always_comb begin
		sec_evt = '0;
		sec_evt[irq_ctrl_pkg::AUX_IDX] = aux_edge;
		// Finish is a level; only its rise is an event
		// Both levels must be high together
		sec_evt[irq_ctrl_pkg::CHECKSUM_IDX] = rose(
			checksum_compute_active_i && checksum_data_done_i, q.chk_prev);
	end

	// Primary requests; bit 7 of the write picks set or clear
	// Command-end and low-alert set at reset
	irq_request_bank #(
		.W         (irq_ctrl_pkg::PRIM_REQ_W),
		.RESET_VAL (irq_ctrl_pkg::PRIM_REQ_RESET[irq_ctrl_pkg::PRIM_REQ_W-1:0])
	) u_prim_req (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.wr_i      (prim_req_wr),
		.mark_i    (reg_wdata_i[irq_ctrl_pkg::PRIM_REQ_W-1:0]),
		.set_sel_i (reg_wdata_i[irq_ctrl_pkg::SET_CLEAR_BIT]),
		.event_i   (prim_evt),
		.req_o     (prim_req)
	);

	// Secondary requests, same mechanism on the two live bits
	// Reserved bits get no storage
	irq_request_bank #(
		.W         (irq_ctrl_pkg::SEC_REQ_W),
		.RESET_VAL (irq_ctrl_pkg::SEC_REQ_RESET[irq_ctrl_pkg::SEC_REQ_W-1:0])
	) u_sec_req (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.wr_i      (sec_req_wr),
		.mark_i    (sec_mark),
		.set_sel_i (reg_wdata_i[irq_ctrl_pkg::SET_CLEAR_BIT]),
		.event_i   (sec_evt),
		.req_o     (sec_req)
	);

	// Next state of enables, edge history, read data and pin
	always_comb begin
		logic level;
		level = 1'b0;
		d     = q;

		// Writes land at the next edge
		// Enable register writes
		if (reg_wr_i && hit(reg_addr_i, irq_ctrl_pkg::PRIM_EN_ADDR)) begin
			d.prim_en = reg_wdata_i;
		end
		if (reg_wr_i && hit(reg_addr_i, irq_ctrl_pkg::SEC_EN_ADDR)) begin
			// Reserved bits are not stored
			d.drive_sel = reg_wdata_i[irq_ctrl_pkg::DRIVE_BIT];
			d.aux_en    = reg_wdata_i[irq_ctrl_pkg::AUX_BIT];
			d.chk_en    = reg_wdata_i[irq_ctrl_pkg::CHECKSUM_BIT];
		end

		// Edge history for the level-type sources
		// A request cleared while its level
		// stays high waits for a new rise
		d.cmd_prev  = command_register_i;
		d.idle_wr   = cmd_host_idle_write_i;
		d.err_prev  = error_flag_register_i;
		d.high_prev = fifo_high_status_i;
		d.low_prev  = fifo_low_status_i;
		d.tmr_nz    = (timer_count_register_i != '0);
		d.chk_prev  = checksum_compute_active_i && checksum_data_done_i;

		// Unknown command: sequencer must fall back to idle
		// Sequencer sees it one cycle later
		d.force_idle = cmd_start_i && !KNOWN_CMD_MASK[cmd_start_code_i];

		// Read data held until the next read
		// Cycles without a read keep old data
		if (reg_rd_i) begin
			d.rdata = '0;
			unique case (reg_addr_i)
				// Polarity reads with the enables
				irq_ctrl_pkg::PRIM_EN_ADDR: begin
					d.rdata = q.prim_en;
				end
				// Three stored bits only
				irq_ctrl_pkg::SEC_EN_ADDR: begin
					d.rdata[irq_ctrl_pkg::DRIVE_BIT]    = q.drive_sel;
					d.rdata[irq_ctrl_pkg::AUX_BIT]      = q.aux_en;
					d.rdata[irq_ctrl_pkg::CHECKSUM_BIT] = q.chk_en;
				end
				irq_ctrl_pkg::PRIM_REQ_ADDR: begin
					// Select bit is write-only and reads zero
					d.rdata[irq_ctrl_pkg::PRIM_REQ_W-1:0] = prim_req;
				end
				// Live bits at register places
				irq_ctrl_pkg::SEC_REQ_ADDR: begin
					d.rdata[irq_ctrl_pkg::AUX_BIT]      = sec_req[irq_ctrl_pkg::AUX_IDX];
					d.rdata[irq_ctrl_pkg::CHECKSUM_BIT] =
						sec_req[irq_ctrl_pkg::CHECKSUM_IDX];
				end
				// Other offsets belong to other blocks and read zero here
				default: begin
					d.rdata = '0;
				end
			endcase
		end

		// Global status from current requests and the next enables
		// Next enables reach the pin at once,
		// at the cost of a longer path
		d.status = |(prim_req & d.prim_en[irq_ctrl_pkg::PRIM_REQ_W-1:0])
			|| (sec_req[irq_ctrl_pkg::AUX_IDX] && d.aux_en)
			|| (sec_req[irq_ctrl_pkg::CHECKSUM_IDX] && d.chk_en);

		// Pin level, inverted when the polarity bit is one
		level = d.status ^ d.prim_en[irq_ctrl_pkg::POLARITY_BIT];

		// Push-pull drives always; open-drain only pulls low
		// Open-drain never drives high, so
		// a shared pulled-up line is safe
		if (d.drive_sel) begin
			d.pin    = level;
			d.pin_oe = 1'b1;
		end else begin
			// High level floats, which is the state after reset
			d.pin    = 1'b0;
			d.pin_oe = !level;
		end
	end

	// State register
	// Synchronous reset only
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			// Read data, status, pin all zero
			q           <= '0;
			q.prim_en   <= irq_ctrl_pkg::PRIM_EN_RESET;
			q.drive_sel <= irq_ctrl_pkg::SEC_EN_RESET[irq_ctrl_pkg::DRIVE_BIT];
			q.aux_en    <= irq_ctrl_pkg::SEC_EN_RESET[irq_ctrl_pkg::AUX_BIT];
			q.chk_en    <= irq_ctrl_pkg::SEC_EN_RESET[irq_ctrl_pkg::CHECKSUM_BIT];
			// History at rest: no event at release
			q.cmd_prev  <= irq_ctrl_pkg::CMD_IDLE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flip-flops
	// Pin and enable change together
	assign reg_rdata_o      = q.rdata;
	assign cmd_force_idle_o = q.force_idle;
	assign irq_status_o     = q.status;
	assign irq_pin_o        = q.pin;
	assign irq_pin_oe_o     = q.pin_oe;

endmodule

`default_nettype wire

// ### testbench/reader_irq_controller_monitor.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module reader_irq_controller_monitor #(
	parameter logic [15:0] KNOWN_CMD_MASK = 16'h00FF // Known command codes
) (
	input wire logic                             clock_i,
	input wire logic                             rst_i,
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0]  reg_addr_i,
	input wire logic                             reg_wr_i,
	input wire logic                             reg_rd_i,
	input wire logic [irq_ctrl_pkg::DATA_W-1:0]  reg_wdata_i,
	input wire logic [irq_ctrl_pkg::DATA_W-1:0]  reg_rdata_o,
	input wire logic                             tx_last_bit_sent_i,
	input wire logic [irq_ctrl_pkg::TIMER_W-1:0] timer_count_register_i,
	input wire logic                             cmd_start_i,
	input wire logic [irq_ctrl_pkg::CMD_W-1:0]   cmd_start_code_i,
	input wire logic                             cmd_force_idle_o,
	input wire logic                             irq_status_o,
	input wire logic                             irq_pin_o,
	input wire logic                             irq_pin_oe_o
);
	logic [7:0] pen_q; // Mirror of primary enable
	logic [7:0] sen_q; // Mirror of secondary enable, live bits

	// Mirror enable writes; pin checks need polarity and drive
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pen_q <= 8'h80;
			sen_q <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == irq_ctrl_pkg::PRIM_EN_ADDR) begin
			pen_q <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == irq_ctrl_pkg::SEC_EN_ADDR) begin
			sen_q <= reg_wdata_i & 8'h94;
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_pin_drive;
		sen_q[7] ? (irq_pin_oe_o && irq_pin_o == (irq_status_o ^ pen_q[7]))
			: (!irq_pin_o && irq_pin_oe_o == !(irq_status_o ^ pen_q[7]));
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong");
	property p_reset_float;
		$fell(rst_i) |-> !irq_pin_oe_o;
	endproperty
	a_reset_float: assert property (p_reset_float) else $error("pin driven after reset");
	property p_tx_status;
		tx_last_bit_sent_i && pen_q[6] && !reg_wr_i ##1 !reg_wr_i |=> irq_status_o;
	endproperty
	a_tx_status: assert property (p_tx_status) else $error("tx status late");
	property p_timer_status;
		$changed(timer_count_register_i) && timer_count_register_i == 16'h0000 && pen_q[0]
			&& !reg_wr_i ##1 !reg_wr_i |=> irq_status_o;
	endproperty
	a_timer_status: assert property (p_timer_status) else $error("timer status late");
	property p_no_enable;
		pen_q[6:0] == 7'h00 && !sen_q[4] && !sen_q[2] |-> !irq_status_o;
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("status without enable");
	property p_force_idle;
		cmd_start_i && !KNOWN_CMD_MASK[cmd_start_code_i] |=> cmd_force_idle_o;
	endproperty
	a_force_idle: assert property (p_force_idle) else $error("no force idle");
	property p_force_quiet;
		!cmd_start_i |=> !cmd_force_idle_o;
	endproperty
	a_force_quiet: assert property (p_force_quiet) else $error("stray force idle");
	property p_prim_read;
		reg_rd_i && reg_addr_i == irq_ctrl_pkg::PRIM_REQ_ADDR |=> !reg_rdata_o[7];
	endproperty
	a_prim_read: assert property (p_prim_read) else $error("select bit read");
	property p_sec_read;
		reg_rd_i && reg_addr_i == irq_ctrl_pkg::SEC_REQ_ADDR |=> (reg_rdata_o & 8'hEB) == 8'h00;
	endproperty
	a_sec_read: assert property (p_sec_read) else $error("reserved bit read");
	property p_unmapped;
		reg_rd_i && (reg_addr_i < 6'h02 || reg_addr_i > 6'h05) |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_rdata_hold;
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	c_tx: cover property (tx_last_bit_sent_i ##2 irq_status_o);
	c_force: cover property (cmd_force_idle_o);
	c_drain: cover property (irq_pin_oe_o && !irq_pin_o);
endmodule

bind reader_irq_controller reader_irq_controller_monitor #(.KNOWN_CMD_MASK(KNOWN_CMD_MASK)) i_mon (
	.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.tx_last_bit_sent_i(tx_last_bit_sent_i), .timer_count_register_i(timer_count_register_i),
	.cmd_start_i(cmd_start_i), .cmd_start_code_i(cmd_start_code_i),
	.cmd_force_idle_o(cmd_force_idle_o), .irq_status_o(irq_status_o),
	.irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));
`default_nettype wire

// ### testbench/irq_host_model.sv
// Host end of the interrupt line, with board pull-up
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
	input  wire logic pin_i,    // Level driven by the device
	input  wire logic pin_oe_i, // Device drive enable
	output logic      line_o    // Level the host samples
);
	// Undriven line is pulled high, never left at its last value
	assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule
`default_nettype wire

// ### testbench/reader_irq_controller_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module reader_irq_controller_tb;
	logic        clock_i = 1'b0; // Bench clock
	logic        rst_i = 1'b1;   // Synchronous reset
	logic [5:0]  addr = 6'h00;   // Register offset
	logic        wr = 1'b0, rd = 1'b0, tx = 1'b0, rx = 1'b0, rx_opt = 1'b0, has_data = 1'b0;
	logic        hi = 1'b0, lo = 1'b0, aux = 1'b1, ck_act = 1'b0, ck_done = 1'b0;
	logic        host_idle = 1'b0, start = 1'b0;
	logic [7:0]  wdata = 8'h00, err = 8'h00, v;
	logic [15:0] timer = 16'h0000;
	logic [3:0]  cmd = 4'h0, code = 4'h0;
	logic [7:0]  rdata;
	logic        force_idle, status, pin, pin_oe, line;
	logic [15:0] lfsr = 16'h9594; // Stimulus seed
	int          miscompares = 0;
	int          compares = 0;
	// Expected request bytes per event source
	localparam logic [7:0] EXP [14] = '{8'h40, 8'h20, 8'h00, 8'h20, 8'h10, 8'h00, 8'h10,
		8'h00, 8'h08, 8'h04, 8'h02, 8'h01, 8'h10, 8'h04};
	localparam logic [5:0] RA [6] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h00, 6'h3F};
	localparam logic [7:0] RV [6] = '{8'h80, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00};

	reader_irq_controller i_dut (
		.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .tx_last_bit_sent_i(tx),
		.rx_stream_end_i(rx), .rx_ignore_empty_option_i(rx_opt), .fifo_has_data_i(has_data),
		.fifo_high_status_i(hi), .fifo_low_status_i(lo), .error_flag_register_i(err),
		.timer_count_register_i(timer), .command_register_i(cmd),
		.cmd_host_idle_write_i(host_idle), .cmd_start_i(start), .cmd_start_code_i(code),
		.cmd_force_idle_o(force_idle), .checksum_compute_active_i(ck_act),
		.checksum_data_done_i(ck_done), .aux_serial_input_i(aux), .irq_status_o(status),
		.irq_pin_o(pin), .irq_pin_oe_o(pin_oe));
	irq_host_model i_host (.pin_i(pin), .pin_oe_i(pin_oe), .line_o(line));

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	// Stimulus generator step
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Status, enable, pin and host line for a drive/polarity setting
	function automatic logic [7:0] exp_pin(input logic drv, input logic pol, input logic st);
		return {4'h0, st, drv | ~(st ^ pol), drv & (st ^ pol), st ^ pol};
	endfunction
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Register write; a spare cycle keeps strobes from toggling twice at once
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clock_i);
		wr = 1'b0;
		@(negedge clock_i);
	endtask
	// Register read; data sampled once the registered answer settles
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		addr = a;
		rd = 1'b1;
		@(negedge clock_i);
		rd = 1'b0;
		@(negedge clock_i);
		d = rdata;
	endtask
	// Drive one event source, then return all sources but the aux pin to rest
	task automatic fire(input int k);
		lfsr = lfsr_next(lfsr);
		case (k)
			0: tx = 1'b1;
			1, 2, 3: begin
				rx_opt = (k != 1);
				has_data = (k == 3);
				rx = 1'b1;
			end
			4, 5: cmd = 4'h1;
			6, 7: begin
				start = 1'b1;
				code = (k == 6) ? 4'hF : 4'h1;
			end
			8: hi = 1'b1;
			9: lo = 1'b1;
			10: err = lfsr[7:0] | 8'h01;
			11: timer = 16'h0005;
			12: aux = ~aux;
			default: begin
				ck_act = 1'b1;
				ck_done = 1'b1;
			end
		endcase
		@(negedge clock_i);
		if (k == 6) chk({7'h00, force_idle}, 8'h01);
		host_idle = (k == 5);
		{tx, rx, start, hi, lo, ck_act, ck_done} = 7'h00;
		err = 8'h00;
		timer = 16'h0000;
		cmd = 4'h0;
		@(negedge clock_i);
		host_idle = 1'b0;
	endtask
	// Verdict and end of run
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly five hundred cycles the tests need
	initial begin
		#200000;
		miscompares++;
		summarize();
	end

	// Main sequence
	initial begin
		repeat (8) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (6) @(negedge clock_i);
		chk({status, pin_oe, pin, line} & 8'h0F, exp_pin(1'b0, 1'b1, 1'b0));
		for (int i = 0; i < 6; i++) begin
			rd_reg(RA[i], v);
			chk(v, RV[i]);
		end
		$display("reset values done");
		lfsr = lfsr_next(lfsr);
		wr_reg(6'h03, lfsr[7:0]);
		wr_reg(6'h00, 8'hFF);
		rd_reg(6'h03, v);
		chk(v, lfsr[7:0] & 8'h94);
		rd_reg(6'h00, v);
		chk(v, 8'h00);
		wr_reg(6'h05, 8'h94);
		rd_reg(6'h05, v);
		chk(v, 8'h14);
		wr_reg(6'h05, 8'h10);
		rd_reg(6'h05, v);
		chk(v, 8'h04);
		$display("enable and set-clear done");
		wr_reg(6'h03, 8'h00);
		wr_reg(6'h02, 8'h41);
		for (int k = 0; k < 14; k++) begin
			wr_reg(6'h04, 8'h7F);
			wr_reg(6'h05, 8'h14);
			fire(k);
			repeat (8) @(negedge clock_i);
			rd_reg((k > 11) ? 6'h05 : 6'h04, v);
			chk(v, EXP[k]);
		end
		$display("event sources done");
		for (int i = 0; i < 4; i++) begin
			wr_reg(6'h03, {i[1], 7'h00});
			wr_reg(6'h02, {i[0], 7'h40});
			wr_reg(6'h04, 8'hC0);
			repeat (2) @(negedge clock_i);
			chk({status, pin_oe, pin, line} & 8'h0F, exp_pin(i[1], i[0], 1'b1));
			wr_reg(6'h02, {i[0], 7'h00});
			repeat (2) @(negedge clock_i);
			chk({status, pin_oe, pin, line} & 8'h0F, exp_pin(i[1], i[0], 1'b0));
		end
		$display("pin modes done");
		for (int n = 0; n < 16; n++) begin
			lfsr = lfsr_next(lfsr);
			wr_reg(6'h04, 8'h7F);
			wr_reg(6'h04, {1'b1, lfsr[6:0]});
			wr_reg(6'h02, {1'b0, lfsr[14:8]});
			repeat (2) @(negedge clock_i);
			chk({7'h00, status}, {7'h00, |(lfsr[6:0] & lfsr[14:8])});
			rd_reg(6'h04, v);
			chk(v, {1'b0, lfsr[6:0]});
		end
		$display("random masks done");
		summarize();
	end
endmodule
`default_nettype wire
